// *** core/bft_pkg.sv ***
package bft_pkg;

    // ==========================================================
    // Register indices, byte address is four times the index
    // ==========================================================
    localparam logic [5:0] BIT_ALIGN_IDX = 6'h0f;
    localparam logic [5:0] TX_OUT_CTRL_IDX = 6'h11;
    localparam logic [5:0] CARRIER_G_IDX = 6'h12;
    localparam logic [5:0] MOD_G_IDX = 6'h13;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] BIT_ALIGN_RST = 8'h00;
    localparam logic [7:0] TX_OUT_CTRL_RST = 8'h58;
    localparam logic [7:0] CARRIER_G_RST = 8'h3f;
    localparam logic [7:0] MOD_G_RST = 8'h3f;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int RX_OFS_LSB = 4;
    localparam int FINAL_CNT_LSB = 0;
    localparam int MOD_SEL_LSB = 5;
    localparam int FULL_ASK_BIT = 4;
    localparam int B_INVERT_BIT = 3;
    localparam int B_CW_BIT = 2;
    localparam int B_RF_EN_BIT = 1;
    localparam int A_RF_EN_BIT = 0;
    localparam int COND_LSB = 0;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        MOD_SRC_LOW,
        MOD_SRC_HIGH,
        MOD_SRC_ENCODER,
        MOD_SRC_EXTERNAL
    } bft_mod_src_type;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } bft_apb_req_type;

    typedef struct packed {
        logic carrier_on;
        logic carrier_invert;
        logic [5:0] conductance;
    } bft_drive_type;

endpackage

// *** core/bft_driver_ctrl.sv ***
`timescale 1ns/1ps

module bft_driver_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire bft_pkg::bft_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_done,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_last,
    output logic tx_byte_ready,
    input wire logic tx_bit_tick,
    output logic tx_done,
    output logic encoder_bit,
    input wire logic external_modulation_input,
    output logic modulator_in,
    output bft_pkg::bft_drive_type antenna_driver_a,
    output bft_pkg::bft_drive_type antenna_driver_b
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] bit_align;
        logic [7:0] tx_ctrl;
        logic [7:0] carrier_g;
        logic [7:0] mod_g;
        logic rx_active;
        logic [2:0] rx_pos;
        logic [7:0] rx_acc;
        logic rx_partial;
        logic rx_byte_valid;
        logic [7:0] rx_byte;
        logic tx_busy;
        logic [7:0] tx_shift;
        logic [3:0] tx_left;
        logic tx_last;
        logic tx_ready;
        logic tx_done;
        logic enc_bit;
        logic mod_in;
        bft_pkg::bft_drive_type drv_a;
        bft_pkg::bft_drive_type drv_b;
    } bft_state_type;

    bft_state_type s_q;
    bft_state_type s_d;

    // ==========================================================
    // Pin synchroniser and antenna driver selection
    // ==========================================================
    logic ext_sync;
    logic [5:0] cw_g;
    logic [5:0] mod_drive_g;
    bft_pkg::bft_drive_type drive_a_d;
    bft_pkg::bft_drive_type drive_b_d;

    // External pin, two stages before use
    bft_sync2 bft_sync2_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(external_modulation_input),
        .sync_out(ext_sync)
    );

    assign cw_g = s_q.carrier_g[bft_pkg::COND_LSB +: 6];
    // full ASK drops conductance to zero
    assign mod_drive_g = s_q.tx_ctrl[bft_pkg::FULL_ASK_BIT] ? 6'h00
        : s_q.mod_g[bft_pkg::COND_LSB +: 6];

    // driver A, plain carrier, never inverted
    bft_drive_pick bft_drive_pick_a_i (
        .rf_enable(s_q.tx_ctrl[bft_pkg::A_RF_EN_BIT]),
        .continuous(1'b0),
        .invert(1'b0),
        .modulating(s_q.mod_in),
        .carrier_g(cw_g),
        .mod_g(mod_drive_g),
        .drive(drive_a_d)
    );

    bft_drive_pick bft_drive_pick_b_i (
        .rf_enable(s_q.tx_ctrl[bft_pkg::B_RF_EN_BIT]),
        .continuous(s_q.tx_ctrl[bft_pkg::B_CW_BIT]),
        .invert(~s_q.tx_ctrl[bft_pkg::B_INVERT_BIT]),
        .modulating(s_q.mod_in),
        .carrier_g(cw_g),
        .mod_g(mod_drive_g),
        .drive(drive_b_d)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic [5:0] idx;
        logic mapped;
        logic access;
        logic [7:0] rdata;
        logic [2:0] pos;
        logic [7:0] acc;
        logic partial;
        logic [2:0] final_cnt;
        bft_pkg::bft_mod_src_type src;

        s_d = s_q;
        idx = apb_req.paddr[7:2];
        access = apb_req.psel & apb_req.penable;
        rdata = 8'h00;
        mapped = 1'b1;
        pos = s_q.rx_pos;
        acc = s_q.rx_acc;
        partial = s_q.rx_partial;
        final_cnt = s_q.bit_align[bft_pkg::FINAL_CNT_LSB +: 3];
        s_d.rx_byte_valid = 1'b0;
        s_d.tx_done = 1'b0;

        // Receive bit packing
        if (rx_bit_valid) begin
            if (!s_q.rx_active) begin
                pos = s_q.bit_align[bft_pkg::RX_OFS_LSB +: 3];
                acc = 8'h00;
            end
            acc[pos] = rx_bit;
            partial = 1'b1;
            s_d.rx_active = 1'b1;
            if (pos == 3'h7) begin
                s_d.rx_byte_valid = 1'b1;
                s_d.rx_byte = acc;
                acc = 8'h00;
                partial = 1'b0;
                pos = 3'h0;
            end else begin
                pos = pos + 3'h1;
            end
        end
        if (rx_done) begin
            // A partial byte is flushed at frame end
            if (partial) begin
                s_d.rx_byte_valid = 1'b1;
                s_d.rx_byte = acc;
            end
            partial = 1'b0;
            acc = 8'h00;
            pos = 3'h0;
            s_d.rx_active = 1'b0;
            s_d.bit_align[bft_pkg::RX_OFS_LSB +: 3] = 3'h0;
        end
        s_d.rx_pos = pos;
        s_d.rx_acc = acc;
        s_d.rx_partial = partial;

        // Transmit serializer, LSB first
        if (s_q.tx_busy && tx_bit_tick) begin
            if (s_q.tx_left == 4'h0) begin
                // Closing tick, so the last bit stands a full bit time
                s_d.tx_busy = 1'b0;
                s_d.enc_bit = 1'b0;
                if (s_q.tx_last) begin
                    s_d.tx_done = 1'b1;
                    s_d.bit_align[bft_pkg::FINAL_CNT_LSB +: 3] = 3'h0;
                end
            end else begin
                s_d.enc_bit = s_q.tx_shift[0];
                s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
                s_d.tx_left = s_q.tx_left - 4'h1;
            end
        end else if (!s_q.tx_busy && tx_byte_valid && s_q.tx_ready) begin
            s_d.tx_busy = 1'b1;
            s_d.tx_shift = tx_byte;
            s_d.tx_last = tx_byte_last;
            if (tx_byte_last && final_cnt != 3'h0) begin
                s_d.tx_left = {1'b0, final_cnt};
            end else begin
                s_d.tx_left = bft_pkg::BITS_PER_BYTE;
            end
        end
        s_d.tx_ready = ~s_d.tx_busy;

        // Register bus, one wait state then answer
        case (idx)
            bft_pkg::BIT_ALIGN_IDX: rdata = s_q.bit_align & 8'h77;
            bft_pkg::TX_OUT_CTRL_IDX: rdata = s_q.tx_ctrl;
            bft_pkg::CARRIER_G_IDX: rdata = s_q.carrier_g;
            bft_pkg::MOD_G_IDX: rdata = s_q.mod_g;
            default: mapped = 1'b0;
        endcase
        s_d.pready = access & ~s_q.pready;
        if (access && !s_q.pready) begin
            s_d.prdata = (apb_req.pwrite || !mapped) ? 32'h0000_0000
                                                      : {24'h000000, rdata};
            s_d.pslverr = ~mapped;
        end else begin
            s_d.pslverr = 1'b0;
        end
        // Software write wins over the self-clears above
        if (access && s_q.pready && apb_req.pwrite && mapped) begin
            case (idx)
                bft_pkg::BIT_ALIGN_IDX: begin
                    s_d.bit_align = apb_req.pwdata[7:0] & 8'h77;
                end
                // bit 7 stored as written; software keeps it
                bft_pkg::TX_OUT_CTRL_IDX: s_d.tx_ctrl = apb_req.pwdata[7:0];
                // top bits stored; software keeps them 00
                bft_pkg::CARRIER_G_IDX: s_d.carrier_g = apb_req.pwdata[7:0];
                bft_pkg::MOD_G_IDX: s_d.mod_g = apb_req.pwdata[7:0];
                default: s_d.mod_g = s_q.mod_g;
            endcase
        end

        // Modulator input source
        src = bft_pkg::bft_mod_src_type'(
            s_q.tx_ctrl[bft_pkg::MOD_SEL_LSB +: 2]);
        case (src)
            bft_pkg::MOD_SRC_LOW: s_d.mod_in = 1'b0;
            bft_pkg::MOD_SRC_HIGH: s_d.mod_in = 1'b1;
            bft_pkg::MOD_SRC_ENCODER: s_d.mod_in = s_q.enc_bit;
            bft_pkg::MOD_SRC_EXTERNAL: s_d.mod_in = ext_sync;
            default: s_d.mod_in = 1'b0;
        endcase

        // Driver picks are combinational, registered here
        s_d.drv_a = drive_a_d;
        s_d.drv_b = drive_b_d;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.bit_align <= bft_pkg::BIT_ALIGN_RST;
            s_q.tx_ctrl <= bft_pkg::TX_OUT_CTRL_RST;
            s_q.carrier_g <= bft_pkg::CARRIER_G_RST;
            s_q.mod_g <= bft_pkg::MOD_G_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign rx_byte_valid = s_q.rx_byte_valid;
    assign rx_byte = s_q.rx_byte;
    assign tx_byte_ready = s_q.tx_ready;
    assign tx_done = s_q.tx_done;
    assign encoder_bit = s_q.enc_bit;
    assign modulator_in = s_q.mod_in;
    assign antenna_driver_a = s_q.drv_a;
    assign antenna_driver_b = s_q.drv_b;

endmodule

// ==========================================================
// Two-stage synchroniser for an asynchronous pin
// ==========================================================
module bft_sync2 (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    typedef struct packed {
        logic meta;
        logic sync;
    } bft_sync_state_type;

    bft_sync_state_type s_q;
    bft_sync_state_type s_d;

    // Only the second stage is read, the first may be metastable
    always_comb begin
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;

endmodule

// ==========================================================
// One antenna driver: carrier gate and conductance pick
// ==========================================================
module bft_drive_pick (
    input wire logic rf_enable,
    input wire logic continuous,
    input wire logic invert,
    input wire logic modulating,
    input wire logic [5:0] carrier_g,
    input wire logic [5:0] mod_g,
    output bft_pkg::bft_drive_type drive
);

    // Carrier conductance unless a live, modulatable carrier pulses
    always_comb begin
        drive.carrier_on = rf_enable;
        drive.carrier_invert = invert;
        if (rf_enable && !continuous && modulating) begin
            drive.conductance = mod_g;
        end else begin
            drive.conductance = carrier_g;
        end
    end

endmodule

// *** tb/bft_properties.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checks: bus timing and antenna driver control
module bft_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire bft_pkg::bft_apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic external_modulation_input,
    input wire logic encoder_bit,
    input wire logic modulator_in,
    input wire bft_pkg::bft_drive_type antenna_driver_a,
    input wire bft_pkg::bft_drive_type antenna_driver_b
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctl_q, cw_q, md_q;
    logic [2:0] quiet_q;
    logic wr, quiet;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
    // Drive checks wait out the output pipeline after any write
    assign quiet = quiet_q == 3'h7;
    // Shadow copy taken from the bus, no peeking inside
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_q <= bft_pkg::TX_OUT_CTRL_RST;
            cw_q <= bft_pkg::CARRIER_G_RST;
            md_q <= bft_pkg::MOD_G_RST;
        end else if (wr) begin
            if (apb_req.paddr == 8'h44) ctl_q <= apb_req.pwdata[7:0];
            if (apb_req.paddr == 8'h48) cw_q <= apb_req.pwdata[7:0];
            if (apb_req.paddr == 8'h4c) md_q <= apb_req.pwdata[7:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || wr) quiet_q <= 3'h0;
        else if (!quiet) quiet_q <= quiet_q + 3'h1;
    end
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_wait;
        apb_req.psel && apb_req.penable && !pready;
    endsequence
    property p_one_wait;
        s_setup ##1 s_wait |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("pready not after one wait state");
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("error response malformed");
    property p_sel_low;
        quiet && ctl_q[6:5] == 2'b00 |-> !modulator_in;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("modulator input not low");
    property p_sel_high;
        quiet && ctl_q[6:5] == 2'b01 |-> modulator_in;
    endproperty
    a_sel_high: assert property (p_sel_high)
        else $error("modulator input not high");
    property p_sel_ext;
        quiet && ctl_q[6:5] == 2'b11
            |-> modulator_in == $past(external_modulation_input, 3);
    endproperty
    a_sel_ext: assert property (p_sel_ext)
        else $error("modulator input not from pin");
    property p_sel_enc;
        quiet && ctl_q[6:5] == 2'b10 |-> modulator_in == $past(encoder_bit);
    endproperty
    a_sel_enc: assert property (p_sel_enc)
        else $error("modulator input not from encoder");
    property p_drv_a;
        quiet |-> antenna_driver_a.carrier_on == ctl_q[0];
    endproperty
    a_drv_a: assert property (p_drv_a)
        else $error("driver a enable wrong");
    property p_drv_b;
        quiet |-> antenna_driver_b.carrier_on == ctl_q[1]
            && antenna_driver_b.carrier_invert == !ctl_q[3];
    endproperty
    a_drv_b: assert property (p_drv_b)
        else $error("driver b enable or invert wrong");
    property p_cond_cw;
        quiet && ctl_q[6:5] == 2'b00
            |-> antenna_driver_a.conductance == cw_q[5:0];
    endproperty
    a_cond_cw: assert property (p_cond_cw)
        else $error("carrier conductance wrong");
    property p_cond_mod;
        quiet && ctl_q[6:5] == 2'b01 && ctl_q[0]
            |-> antenna_driver_a.conductance == (ctl_q[4] ? 6'h00 : md_q[5:0]);
    endproperty
    a_cond_mod: assert property (p_cond_mod)
        else $error("modulation conductance wrong");
endmodule
bind bft_driver_ctrl bft_properties bft_properties_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_modulation_input(external_modulation_input),
    .encoder_bit(encoder_bit), .modulator_in(modulator_in),
    .antenna_driver_a(antenna_driver_a),
    .antenna_driver_b(antenna_driver_b));

// *** tb/bft_card_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Card side: answers with bits, clocks frames out
module bft_card_model (
    input wire logic ref_clk,
    input wire logic encoder_bit,
    input wire logic tx_done,
    output logic rx_bit_valid = 1'b0,
    output logic rx_bit = 1'b0,
    output logic rx_done = 1'b0,
    output logic tx_bit_tick = 1'b0
);
    // Bit line flips after each bit so stale data never looks fresh
    task automatic reply(input logic [7:0] bits, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge ref_clk);
            rx_bit_valid <= 1'b1;
            rx_bit <= bits[i];
            @(posedge ref_clk);
            rx_bit_valid <= 1'b0;
            rx_bit <= ~bits[i];
        end
        rx_done <= 1'b1;
        @(posedge ref_clk);
        rx_done <= 1'b0;
    endtask
    task automatic listen(input int gap, output int n, output logic [7:0] cap);
        n = 0;
        cap = 8'h00;
        while (n < 9) begin
            repeat (gap) @(posedge ref_clk);
            tx_bit_tick <= 1'b1;
            @(posedge ref_clk);
            tx_bit_tick <= 1'b0;
            n++;
            @(posedge ref_clk);
            if (tx_done) break;
            cap[n-1] = encoder_bit;
        end
    endtask
endmodule

// *** tb/bft_driver_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module bft_driver_ctrl_tb_top;
    localparam logic [7:0] A_ALIGN = {bft_pkg::BIT_ALIGN_IDX, 2'b00};
    localparam logic [7:0] A_CTL = {bft_pkg::TX_OUT_CTRL_IDX, 2'b00};
    localparam logic [7:0] A_CW = {bft_pkg::CARRIER_G_IDX, 2'b00};
    localparam logic [7:0] A_MOD = {bft_pkg::MOD_G_IDX, 2'b00};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    bft_pkg::bft_apb_req_type apb_req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_bit_valid, rx_bit, rx_done, rx_byte_valid;
    logic [7:0] rx_byte, cap, tx_byte = 8'h00;
    logic tx_byte_valid = 1'b0, tx_byte_last = 1'b0, tx_byte_ready;
    logic tx_bit_tick, tx_done, encoder_bit, ext_in = 1'b0, modulator_in;
    bft_pkg::bft_drive_type drv_a, drv_b;
    logic [7:0] ctl[7] = '{8'h03, 8'h23, 8'h27, 8'h33, 8'h6b, 8'h46, 8'h58};
    logic [5:0] g_a, g_b, g_m;
    logic [7:0] rxq[$];
    int n, n_mismatch = 0, cmp_count = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) ext_in <= ~ext_in;
    always @(posedge ref_clk) if (rx_byte_valid) rxq.push_back(rx_byte);
    bft_driver_ctrl bft_driver_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .rx_done(rx_done), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
        .tx_byte_last(tx_byte_last), .tx_byte_ready(tx_byte_ready),
        .tx_bit_tick(tx_bit_tick), .tx_done(tx_done),
        .encoder_bit(encoder_bit), .external_modulation_input(ext_in),
        .modulator_in(modulator_in), .antenna_driver_a(drv_a),
        .antenna_driver_b(drv_b));
    bft_card_model bft_card_model_i (.ref_clk(ref_clk),
        .encoder_bit(encoder_bit), .tx_done(tx_done),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_done(rx_done),
        .tx_bit_tick(tx_bit_tick));
    // ==========================================================
    // Bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [7:0] d, output logic [31:0] r, output logic e);
        apb_req.paddr <= a;
        apb_req.pwrite <= w;
        apb_req.pwdata <= {24'h0, d};
        apb_req.psel <= 1'b1;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 8'h00, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(A_ALIGN, 32'h00, 1'b0);
        rd(A_CTL, 32'h58, 1'b0);
        rd(A_CW, 32'h3f, 1'b0);
        rd(A_MOD, 32'h3f, 1'b0);
        rd(8'h50, 32'h0, 1'b1);
        wr(A_ALIGN, 8'hff);
        rd(A_ALIGN, 32'h77, 1'b0);
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            rxq.delete();
            wr(A_ALIGN, i ? 8'h70 : 8'h10);
            bft_card_model_i.reply(i ? 8'h03 : 8'h05, i ? 2 : 3, i + 1);
            repeat (4) @(posedge ref_clk);
            chk(rxq.size(), i + 1);
            chk(rxq[0], i ? 8'h80 : 8'h0a);
            if (i) chk(rxq[1], 8'h01);
            rd(A_ALIGN, 32'h00, 1'b0);
        end
        $display("test receive done");
        for (int i = 0; i < 2; i++) begin
            wr(A_ALIGN, i ? 8'h00 : 8'h03);
            chk(tx_byte_ready, 1'b1);
            tx_byte <= 8'ha5;
            tx_byte_valid <= 1'b1;
            tx_byte_last <= 1'b1;
            @(posedge ref_clk);
            tx_byte_valid <= 1'b0;
            // Ticks counted include the closing one after the last bit
            bft_card_model_i.listen(2 - i, n, cap);
            chk(n, i ? 9 : 4);
            chk(cap, i ? 8'ha5 : 8'h05);
            rd(A_ALIGN, 32'h00, 1'b0);
        end
        $display("test transmit done");
        wr(A_CW, 8'h15);
        wr(A_MOD, 8'h2a);
        foreach (ctl[i]) begin
            wr(A_CTL, ctl[i]);
            repeat (8) @(posedge ref_clk);
            rd(A_CTL, {24'h0, ctl[i]}, 1'b0);
            chk(drv_a.carrier_on, ctl[i][0]);
            chk(drv_b.carrier_on, ctl[i][1]);
            chk(drv_b.carrier_invert, !ctl[i][3]);
            // Pin source toggles every cycle, so its drive is not fixed
            if (ctl[i][6:5] != 2'b11) begin
                g_m = ctl[i][6:5] != 2'b01 ? 6'h15 : ctl[i][4] ? 6'h00 : 6'h2a;
                g_a = ctl[i][0] ? g_m : 6'h15;
                g_b = ctl[i][2:1] == 2'b01 ? g_m : 6'h15;
                chk(modulator_in, ctl[i][6:5] == 2'b01);
                chk(drv_a.conductance, g_a);
                chk(drv_b.conductance, g_b);
            end
        end
        $display("test drivers done");
        test_done();
    end
endmodule
